// file: common/pp_homing_pkg.sv
// constants for profile position and homing method select
// Contract
// - writing mode select starts that mode
// - plain new setpoint: move, stop at target
// - change on setpoint: move, no stop
// - immediate change applies new values at once
// - bit 6 selects absolute or relative target
// - latch position, velocity, accel, decel together; during a move only position is latched, plus velocity if immediate
// - status bit 10 shows target reached
// - status bit 12 shows setpoint accepted
// - end on target, halt, quick stop, error
// - target position is signed 32 bit
// - clamp target velocity to both maxima
// - homing method 1..35, default 18
// - codes 1,2,8..14 use index pulse
// - codes 17,18,23..30 without index pulse
// - 31,34 index search; 35 set position
// - inverted codes reverse at the switch
// - homing sets bits 10 and 12 when done
package pp_homing_pkg;
  localparam logic [15:0] HOMING_METHOD_OFFSET = 16'h1b18;
  localparam logic [15:0] TARGET_VELOCITY_OFFSET = 16'h1b1a;
  localparam logic [15:0] TARGET_POSITION_OFFSET = 16'h1b1c;
  localparam logic [15:0] HOMING_METHOD_RESET = 16'h0012;
  localparam logic [15:0] HOMING_METHOD_MIN = 16'h0001;
  localparam logic [15:0] HOMING_METHOD_MAX = 16'h0023;
  localparam int CW_NEW_SETPOINT = 4;
  localparam int CW_CHANGE_IMMEDIATE = 5;
  localparam int CW_RELATIVE = 6;
  localparam int CW_HALT = 8;
  localparam int CW_CHANGE_ON_SETPOINT = 9;
  localparam int SW_TARGET_REACHED = 10;
  localparam int SW_SETPOINT_ACK = 12;
  localparam logic [7:0] MODE_PROFILE_POSITION = 8'h01;
  localparam logic [7:0] MODE_HOMING = 8'h06;
  localparam logic [31:0] STEP_LIMIT = 32'h00000001;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_MOVE = 4'b0010,
    ST_HOMING = 4'b0100,
    ST_DONE = 4'b1000
  } pp_state_t;
endpackage

// file: src/profile_position_homing.sv
// profile position motion and homing method decode
`timescale 1ns/10ps
module profile_position_homing #(
  parameter int POS_W = 32
) (
  input  wire logic        i_ref_clk,
  input  wire logic        i_reset_n,
  input  wire logic        i_mode_wr,
  input  wire logic [7:0]  i_mode_select_param,
  input  wire logic [15:0] i_drive_control_word,
  input  wire logic        i_param_wr,
  input  wire logic [15:0] i_param_addr,
  input  wire logic [31:0] i_param_wdata,
  input  wire logic [31:0] i_accel,
  input  wire logic [31:0] i_decel,
  input  wire logic [31:0] i_ctrl_v_max,
  input  wire logic [31:0] i_ramp_v_max,
  input  wire logic        i_quick_stop,
  input  wire logic        i_fault,
  input  wire logic        i_home_found,
  output logic [31:0]      o_param_rdata,
  output logic [15:0]      o_drive_status_word,
  output logic [31:0]      o_actual_position,
  output logic [31:0]      o_cmd_velocity,
  output logic [31:0]      o_cmd_accel,
  output logic [31:0]      o_cmd_decel,
  output logic             o_homing_index_used,
  output logic             o_homing_limit_used,
  output logic             o_homing_dir_pos,
  output logic             o_homing_invert,
  output logic             o_homing_set_only
);
  initial begin
    if (POS_W != 32) $error("POS_W must be 32");
  end

  logic [1:0] rst_sync_ff;
  logic rst_n;
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) rst_sync_ff <= 2'h0;
    else rst_sync_ff <= {rst_sync_ff[0], 1'b1};
  end
  assign rst_n = rst_sync_ff[1];

  // pins are async to the control cycle
  logic [2:0] pin_meta_ff;
  logic [2:0] pin_ff;
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_ff <= 3'h0;
      pin_ff <= 3'h0;
    end else begin
      pin_meta_ff <= {i_quick_stop, i_fault, i_home_found};
      pin_ff <= pin_meta_ff;
    end
  end
  logic quick_stop, fault, home_found;
  assign quick_stop = pin_ff[2];
  assign fault = pin_ff[1];
  assign home_found = pin_ff[0];

  function automatic logic signed [31:0] clamp_v(input logic signed [31:0] v,
                                                 input logic [31:0] m);
    logic signed [31:0] lim;
    lim = $signed(m);
    if (v > lim) clamp_v = lim;
    else if (v < -lim) clamp_v = -lim;
    else clamp_v = v;
  endfunction

  logic [15:0] homing_method_ff;
  logic signed [31:0] target_velocity_ff;
  logic signed [31:0] target_position_ff;
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      homing_method_ff <= pp_homing_pkg::HOMING_METHOD_RESET;
      target_velocity_ff <= 32'h0;
      target_position_ff <= 32'h0;
    end else if (i_param_wr) begin
      if (i_param_addr == pp_homing_pkg::HOMING_METHOD_OFFSET &&
          i_param_wdata[15:0] >= pp_homing_pkg::HOMING_METHOD_MIN &&
          i_param_wdata[15:0] <= pp_homing_pkg::HOMING_METHOD_MAX)
        homing_method_ff <= i_param_wdata[15:0];
      if (i_param_addr == pp_homing_pkg::TARGET_VELOCITY_OFFSET)
        target_velocity_ff <= i_param_wdata;
      if (i_param_addr == pp_homing_pkg::TARGET_POSITION_OFFSET)
        target_position_ff <= i_param_wdata;
    end
  end

  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) o_param_rdata <= 32'h0;
    else case (i_param_addr)
      pp_homing_pkg::HOMING_METHOD_OFFSET: o_param_rdata <= {16'h0, homing_method_ff};
      pp_homing_pkg::TARGET_VELOCITY_OFFSET: o_param_rdata <= target_velocity_ff;
      pp_homing_pkg::TARGET_POSITION_OFFSET: o_param_rdata <= target_position_ff;
      default: o_param_rdata <= 32'h0;
    endcase
  end

  logic [7:0] mode_ff;
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) mode_ff <= 8'h0;
    else if (i_mode_wr) mode_ff <= i_mode_select_param;
  end

  logic new_sp_d_ff;
  logic new_sp_rise;
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) new_sp_d_ff <= 1'b0;
    else new_sp_d_ff <= i_drive_control_word[pp_homing_pkg::CW_NEW_SETPOINT];
  end
  assign new_sp_rise = i_drive_control_word[pp_homing_pkg::CW_NEW_SETPOINT] & ~new_sp_d_ff;

  logic cw_imm, cw_cos, cw_rel, stop_req;
  assign cw_imm = i_drive_control_word[pp_homing_pkg::CW_CHANGE_IMMEDIATE];
  assign cw_cos = i_drive_control_word[pp_homing_pkg::CW_CHANGE_ON_SETPOINT];
  assign cw_rel = i_drive_control_word[pp_homing_pkg::CW_RELATIVE];
  assign stop_req = i_drive_control_word[pp_homing_pkg::CW_HALT] | quick_stop | fault;

  logic signed [31:0] new_goal;
  assign new_goal = cw_rel ? o_actual_position + target_position_ff : target_position_ff;

  pp_homing_pkg::pp_state_t state_ff;
  logic signed [31:0] goal_ff;
  logic signed [31:0] pend_goal_ff;
  logic pend_ff, no_stop_ff, reached_ff, ack_ff, home_ok_ff;
  logic at_goal;
  assign at_goal = (o_actual_position == goal_ff);

  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= pp_homing_pkg::ST_IDLE;
      goal_ff <= 32'h0;
      pend_goal_ff <= 32'h0;
      pend_ff <= 1'b0;
      no_stop_ff <= 1'b0;
      reached_ff <= 1'b0;
      ack_ff <= 1'b0;
      home_ok_ff <= 1'b0;
      o_cmd_velocity <= 32'h0;
      o_cmd_accel <= 32'h0;
      o_cmd_decel <= 32'h0;
    end else begin
      // bit 12 follows the setpoint bit handshake
      if (!i_drive_control_word[pp_homing_pkg::CW_NEW_SETPOINT] && !pend_ff) ack_ff <= 1'b0;
      case (state_ff)
        pp_homing_pkg::ST_IDLE, pp_homing_pkg::ST_DONE: begin
          // only a control word edge starts
          if (i_mode_wr) reached_ff <= 1'b0;
          if (new_sp_rise && !stop_req && mode_ff == pp_homing_pkg::MODE_PROFILE_POSITION) begin
            goal_ff <= new_goal;
            o_cmd_velocity <= clamp_v(clamp_v(target_velocity_ff, i_ctrl_v_max), i_ramp_v_max);
            o_cmd_accel <= i_accel;
            o_cmd_decel <= i_decel;
            no_stop_ff <= cw_cos & ~cw_imm;
            reached_ff <= 1'b0;
            ack_ff <= 1'b1;
            state_ff <= pp_homing_pkg::ST_MOVE;
          end else if (new_sp_rise && !stop_req && mode_ff == pp_homing_pkg::MODE_HOMING) begin
            reached_ff <= 1'b0;
            home_ok_ff <= 1'b0;
            state_ff <= pp_homing_pkg::ST_HOMING;
          end
        end
        pp_homing_pkg::ST_MOVE: begin
          if (new_sp_rise && cw_imm) begin
            goal_ff <= new_goal;
            o_cmd_velocity <= clamp_v(clamp_v(target_velocity_ff, i_ctrl_v_max), i_ramp_v_max);
            ack_ff <= 1'b1;
          end else if (new_sp_rise) begin
            pend_goal_ff <= new_goal;
            pend_ff <= 1'b1;
            no_stop_ff <= cw_cos;
            ack_ff <= 1'b1;
          end
          // halt, quick stop or error ends move
          if (stop_req) begin
            pend_ff <= 1'b0;
            state_ff <= pp_homing_pkg::ST_IDLE;
          end else if (at_goal && pend_ff) begin
            goal_ff <= pend_goal_ff;
            pend_ff <= 1'b0;
            reached_ff <= ~no_stop_ff;
          end else if (at_goal) begin
            reached_ff <= 1'b1;
            state_ff <= pp_homing_pkg::ST_DONE;
          end
        end
        pp_homing_pkg::ST_HOMING: begin
          if (stop_req) begin
            reached_ff <= 1'b1;
            state_ff <= pp_homing_pkg::ST_IDLE;
          end else if (home_found || o_homing_set_only) begin
            reached_ff <= 1'b1;
            home_ok_ff <= 1'b1;
            state_ff <= pp_homing_pkg::ST_DONE;
          end
        end
        default: state_ff <= pp_homing_pkg::ST_IDLE;
      endcase
    end
  end

  // simple unit-step trajectory; a real profile generator replaces this
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) o_actual_position <= 32'h0;
    else if (state_ff == pp_homing_pkg::ST_MOVE && !at_goal) begin
      if (goal_ff > o_actual_position)
        o_actual_position <= o_actual_position + pp_homing_pkg::STEP_LIMIT;
      else o_actual_position <= o_actual_position - pp_homing_pkg::STEP_LIMIT;
    end else if (state_ff == pp_homing_pkg::ST_HOMING && o_homing_set_only)
      o_actual_position <= 32'h0;
  end

  // bit 12 accepted, bit 10 reached
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) o_drive_status_word <= 16'h0;
    else begin
      o_drive_status_word <= 16'h0;
      o_drive_status_word[pp_homing_pkg::SW_TARGET_REACHED] <= reached_ff;
      o_drive_status_word[pp_homing_pkg::SW_SETPOINT_ACK] <=
        (mode_ff == pp_homing_pkg::MODE_HOMING) ? home_ok_ff : ack_ff;
    end
  end

  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_homing_index_used <= 1'b0;
      o_homing_limit_used <= 1'b0;
      o_homing_dir_pos <= 1'b0;
      o_homing_invert <= 1'b0;
      o_homing_set_only <= 1'b0;
    end else begin
      o_homing_index_used <= 1'b0;
      o_homing_limit_used <= 1'b0;
      o_homing_dir_pos <= 1'b0;
      o_homing_invert <= 1'b0;
      o_homing_set_only <= 1'b0;
      case (homing_method_ff)
        16'h0001: begin o_homing_index_used <= 1'b1; o_homing_limit_used <= 1'b1; end
        16'h0002: begin
          o_homing_index_used <= 1'b1;
          o_homing_limit_used <= 1'b1;
          o_homing_dir_pos <= 1'b1;
          o_homing_invert <= 1'b1;
        end
        16'h0008, 16'h0009, 16'h000a: begin
          o_homing_index_used <= 1'b1;
          o_homing_dir_pos <= 1'b1;
          o_homing_invert <= (homing_method_ff == 16'h0008);
        end
        16'h000b, 16'h000c, 16'h000d, 16'h000e: begin
          o_homing_index_used <= 1'b1;
          o_homing_invert <= (homing_method_ff == 16'h000c);
        end
        16'h0011: o_homing_limit_used <= 1'b1;
        16'h0012: begin o_homing_limit_used <= 1'b1; o_homing_dir_pos <= 1'b1; end
        16'h0017, 16'h0018, 16'h0019, 16'h001a: begin
          o_homing_dir_pos <= 1'b1;
          o_homing_invert <= (homing_method_ff <= 16'h0018);
        end
        16'h001b, 16'h001c, 16'h001d, 16'h001e:
          o_homing_invert <= (homing_method_ff <= 16'h001c);
        16'h001f: o_homing_index_used <= 1'b1;
        16'h0022: begin o_homing_index_used <= 1'b1; o_homing_dir_pos <= 1'b1; end
        16'h0023: o_homing_set_only <= 1'b1;
        default: o_homing_set_only <= 1'b0;
      endcase
    end
  end

  AST_REACHED_AT_GOAL: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    (state_ff == pp_homing_pkg::ST_MOVE && at_goal && !pend_ff && !stop_req)
    |=> reached_ff) else $error("reached not set at goal");
  AST_NO_LEVEL_START: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    ((state_ff == pp_homing_pkg::ST_IDLE || state_ff == pp_homing_pkg::ST_DONE) &&
     new_sp_d_ff) |=> state_ff != pp_homing_pkg::ST_MOVE)
    else $error("move started on level");
  AST_STOP_ENDS: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    (state_ff == pp_homing_pkg::ST_MOVE && stop_req) |=> state_ff == pp_homing_pkg::ST_IDLE)
    else $error("stop ignored");
  AST_METHOD_RANGE: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    homing_method_ff >= 16'h0001 && homing_method_ff <= 16'h0023)
    else $error("method out of range");
  // accept shown one cycle after start
  AST_ACK_SHOWN: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    $rose(state_ff == pp_homing_pkg::ST_MOVE)
    |=> o_drive_status_word[12] || mode_ff != pp_homing_pkg::MODE_PROFILE_POSITION)
    else $error("accept bit missing");
  // rising setpoint bit starts a move
  AST_RISE_STARTS: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    ((state_ff == pp_homing_pkg::ST_IDLE || state_ff == pp_homing_pkg::ST_DONE) &&
     new_sp_rise && !stop_req && mode_ff == pp_homing_pkg::MODE_PROFILE_POSITION)
    |=> state_ff == pp_homing_pkg::ST_MOVE) else $error("rising setpoint did not start");
endmodule

// file: testbench/pp_master_model.sv
// fieldbus master model: mode, control word and parameter traffic
`timescale 1ns/10ps
module pp_master_model (
  input  wire logic        i_ref_clk,
  input  wire logic [31:0] i_param_rdata,
  output logic             o_mode_wr,
  output logic [7:0]       o_mode_select_param,
  output logic [15:0]      o_drive_control_word,
  output logic             o_param_wr,
  output logic [15:0]      o_param_addr,
  output logic [31:0]      o_param_wdata
);
  initial begin
    o_mode_wr = 1'b0;
    o_mode_select_param = 8'h00;
    o_drive_control_word = 16'h0000;
    o_param_wr = 1'b0;
    o_param_addr = 16'h0000;
    o_param_wdata = 32'h00000000;
  end
  task automatic set_mode(input logic [7:0] m);
    @(posedge i_ref_clk);
    #1;
    o_mode_select_param = m;
    o_mode_wr = 1'b1;
    @(posedge i_ref_clk);
    #1;
    o_mode_wr = 1'b0;
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    #1;
    o_param_addr = a;
    o_param_wdata = d;
    o_param_wr = 1'b1;
    @(posedge i_ref_clk);
    #1;
    o_param_wr = 1'b0;
    // stale data would hide a late sample
    o_param_wdata = ~d;
  endtask
  task automatic rd(input logic [15:0] a, output logic [31:0] d);
    @(posedge i_ref_clk);
    #1;
    o_param_addr = a;
    @(posedge i_ref_clk);
    #1;
    d = i_param_rdata;
  endtask
  // moves start only through control word
  task automatic set_cw(input logic [15:0] cw);
    @(posedge i_ref_clk);
    #1;
    o_drive_control_word = cw;
  endtask
endmodule

// file: testbench/profile_position_and_homing_select_test.sv
// self-checking bench for profile position and homing select
`timescale 1ns/10ps
module profile_position_and_homing_select_test;
  logic        clk;
  logic        rst_n;
  logic [31:0] accel;
  logic [31:0] decel;
  logic [31:0] vmax_c;
  logic [31:0] vmax_r;
  logic        mode_wr;
  logic [7:0]  mode;
  logic [15:0] cw;
  logic        pwr;
  logic [15:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] rdata;
  logic [15:0] sts;
  logic [31:0] pos;
  logic [31:0] cvel;
  logic [31:0] cacc;
  logic [31:0] cdec;
  logic        h_idx;
  logic        h_lim;
  logic        h_set;
  logic        h_dir;
  logic        h_inv;
  logic        qstop;
  logic        flt;
  logic        hfound;
  logic [31:0] seed;
  logic [31:0] rv;
  int          n_fail;
  int          checks;
  int          exp_pos;
  int          v;
  int          vlim;
  int          tgt;
  logic [15:0] cw_mod [3] = '{16'h0000, 16'h0040, 16'h0020};
  int          codes [9] = '{1, 2, 8, 14, 17, 18, 23, 30, 35};

  profile_position_homing DUT (.i_ref_clk(clk), .i_reset_n(rst_n), .i_mode_wr(mode_wr),
    .i_mode_select_param(mode), .i_drive_control_word(cw), .i_param_wr(pwr),
    .i_param_addr(paddr), .i_param_wdata(pwdata), .i_accel(accel), .i_decel(decel),
    .i_ctrl_v_max(vmax_c), .i_ramp_v_max(vmax_r), .i_quick_stop(qstop), .i_fault(flt),
    .i_home_found(hfound), .o_param_rdata(rdata), .o_drive_status_word(sts),
    .o_actual_position(pos), .o_cmd_velocity(cvel), .o_cmd_accel(cacc), .o_cmd_decel(cdec),
    .o_homing_index_used(h_idx), .o_homing_limit_used(h_lim), .o_homing_dir_pos(h_dir),
    .o_homing_invert(h_inv), .o_homing_set_only(h_set));
  pp_master_model m (.i_ref_clk(clk), .i_param_rdata(rdata), .o_mode_wr(mode_wr),
    .o_mode_select_param(mode), .o_drive_control_word(cw), .o_param_wr(pwr),
    .o_param_addr(paddr), .o_param_wdata(pwdata));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    if (n_fail == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wait_bit(input int b, input logic val);
    int k;
    for (k = 0; k < 300 && sts[b] !== val; k++) begin
      @(posedge clk);
      #1;
    end
    if (k == 300) begin
      n_fail++;
      summarize();
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial begin
    n_fail = 0;
    checks = 0;
    seed = 32'h28dd6225;
    rst_n = 1'b0;
    qstop = 1'b0;
    flt = 1'b0;
    hfound = 1'b0;
    accel = 32'h00000010;
    decel = 32'h00000020;
    vmax_c = 32'h00000028;
    vmax_r = 32'h00000028;
    repeat (12) @(posedge clk);
    #1;
    rst_n = 1'b1;
    idle(3);
    m.rd(16'h1b18, rv);
    check(rv, 32'h00000012);
    m.rd(16'h1b1e, rv);
    check(rv, 32'h00000000);
    m.set_mode(8'h01);
    exp_pos = 0;
    for (int i = 0; i < 3; i++) begin
      seed = lfsr(seed);
      tgt = int'(seed[4:0]) + 1;
      v = int'(seed[12:5]) - 128;
      vmax_r = {26'h0, seed[20:15]} + 32'h14;
      accel = lfsr(seed);
      decel = ~seed;
      m.wr(16'h1b1c, tgt);
      m.wr(16'h1b1a, v);
      m.rd(16'h1b1c, rv);
      check(rv, tgt);
      // only the rising new setpoint bit starts
      m.set_cw(cw_mod[i] | 16'h0010);
      exp_pos = cw_mod[i][6] ? exp_pos + tgt : tgt;
      vlim = (int'(vmax_r) < 40) ? int'(vmax_r) : 40;
      v = (v > vlim) ? vlim : ((v < -vlim) ? -vlim : v);
      wait_bit(12, 1'b1);
      check(cvel, v);
      check(cacc, accel);
      check(cdec, decel);
      wait_bit(10, 1'b1);
      check(pos, exp_pos);
      check(sts[10], 1'b1);
      // level held high must not restart
      m.wr(16'h1b1c, exp_pos + 7);
      idle(20);
      check(pos, exp_pos);
      m.set_cw(16'h0000);
      wait_bit(12, 1'b0);
      check(sts[12], 1'b0);
    end
    // halt refuses a start
    m.set_cw(16'h0110);
    idle(20);
    check(pos, exp_pos);
    m.set_cw(16'h0000);
    // fault refuses a start; pin needs sync time
    flt = 1'b1;
    idle(3);
    m.set_cw(16'h0010);
    idle(20);
    check(pos, exp_pos);
    flt = 1'b0;
    m.set_cw(16'h0000);
    // buffered setpoint taken at the first target
    m.wr(16'h1b1c, exp_pos + 30);
    m.set_cw(16'h0210);
    wait_bit(12, 1'b1);
    m.wr(16'h1b1c, exp_pos + 40);
    m.set_cw(16'h0200);
    m.set_cw(16'h0210);
    exp_pos = exp_pos + 40;
    wait_bit(10, 1'b1);
    check(pos, exp_pos);
    // quick stop mid move freezes position
    m.set_cw(16'h0000);
    m.wr(16'h1b1c, exp_pos + 100);
    m.set_cw(16'h0010);
    wait_bit(12, 1'b1);
    qstop = 1'b1;
    idle(6);
    rv = pos;
    idle(4);
    check(pos, rv);
    check(sts[10], 1'b0);
    qstop = 1'b0;
    m.set_cw(16'h0000);
    foreach (codes[i]) begin
      m.wr(16'h1b18, codes[i]);
      idle(2);
      check(h_idx, codes[i] inside {1, 2, [8:14]});
      check(h_lim, codes[i] inside {1, 2, 17, 18});
      check(h_set, codes[i] == 35);
      check(h_dir, codes[i] inside {2, 8, 9, 10, 18, 23, 24, 25, 26, 34});
      check(h_inv, codes[i] inside {2, 8, 12, 23, 24, 27, 28});
    end
    m.wr(16'h1b18, 32'h00000024);
    m.wr(16'h1b18, 32'h00000000);
    m.rd(16'h1b18, rv);
    check(rv, 32'h00000023);
    m.set_mode(8'h06);
    m.set_cw(16'h0010);
    wait_bit(10, 1'b1);
    wait_bit(12, 1'b1);
    check(pos, 32'h00000000);
    m.set_cw(16'h0000);
    idle(4);
    // limit switch homing waits for the found pin
    m.wr(16'h1b18, 32'h00000012);
    m.set_cw(16'h0010);
    idle(3);
    check(sts[10], 1'b0);
    hfound = 1'b1;
    wait_bit(10, 1'b1);
    check(sts[12], 1'b1);
    hfound = 1'b0;
    m.set_cw(16'h0000);
    idle(4);
    summarize();
  end
endmodule
